// File: include/pwmg_defines.vh
// Register indices, field positions, reset values of the PWM generator
`ifndef PWMG_DEFINES_VH
`define PWMG_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define PWMG_IDX_BOUND_HIGH   10'h01a
`define PWMG_IDX_BOUND_LOW    10'h01b
`define PWMG_IDX_CONTROL      10'h030
`define PWMG_IDX_SCALING      10'h031
`define PWMG_IDX_DUTY_HIGH    10'h032
`define PWMG_IDX_DUTY_LOW     10'h033

// ==========================================================
// Internal register select codes
`define PWMG_SEL_NONE         3'h0
`define PWMG_SEL_BOUND_HIGH   3'h1
`define PWMG_SEL_BOUND_LOW    3'h2
`define PWMG_SEL_CONTROL      3'h3
`define PWMG_SEL_SCALING      3'h4
`define PWMG_SEL_DUTY_HIGH    3'h5
`define PWMG_SEL_DUTY_LOW     3'h6

// ==========================================================
// Control register fields
`define PWMG_CTL_EN           7
`define PWMG_CTL_OUT          6
`define PWMG_CTL_POL          5
`define PWMG_CTL_CLR          4
`define PWMG_CTL_PIN_HI       3
`define PWMG_CTL_PIN_LO       1
`define PWMG_CTL_SRC          0

// ==========================================================
// Scaling register fields
`define PWMG_SCL_IMODE        7
`define PWMG_SCL_PRE_HI       6
`define PWMG_SCL_PRE_LO       5
`define PWMG_SCL_DIV_HI       4
`define PWMG_SCL_DIV_LO       0

// ==========================================================
// Low byte registers carry three value bits on top
`define PWMG_LOW_HI           7
`define PWMG_LOW_LO           5

// ==========================================================
// Reset values and pin codes
`define PWMG_RST_BYTE         8'h00
`define PWMG_RST_LOW3         3'h0
`define PWMG_PIN_NONE         3'h0
`define PWMG_PIN_FIRST        3'h2
`define PWMG_PRE_DIV1         2'h0
`define PWMG_PRE_DIV4         2'h1
`define PWMG_PRE_DIV16        2'h2
`define PWMG_PRE_DIV64        2'h3
`define PWMG_PRE_MASK1        6'h00
`define PWMG_PRE_MASK4        6'h03
`define PWMG_PRE_MASK16       6'h0f
`define PWMG_PRE_MASK64       6'h3f

`endif

// File: verilog/pwmg_tick.v
// Clock source selection, prescaler and divider of the PWM generator
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_defines.vh"

module pwmg_tick #(
	parameter DIV_W = 5
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst_n,
	// Control
	input  wire             i_run,
	input  wire             i_clear,
	input  wire             i_src_fast,
	input  wire             i_fast_rc,
	input  wire [1:0]       i_pre_sel,
	input  wire [DIV_W-1:0] i_div,
	// Tick out
	output reg              o_tick
);

	// ==========================================================
	// Prescale limit decode
	function [5:0] pre_mask;
		input [1:0] sel;
		begin
			case (sel)
				`PWMG_PRE_DIV1:  pre_mask = `PWMG_PRE_MASK1;
				`PWMG_PRE_DIV4:  pre_mask = `PWMG_PRE_MASK4;
				`PWMG_PRE_DIV16: pre_mask = `PWMG_PRE_MASK16;
				default:         pre_mask = `PWMG_PRE_MASK64;
			endcase
		end
	endfunction

	reg             rc_prev;
	reg [5:0]       pre_cnt;
	reg [DIV_W-1:0] div_cnt;
	wire            base_tick;
	wire            pre_tick;
	wire            div_tick;

	// Fast RC clock is sampled; only its rising edges count
	assign base_tick = i_src_fast ? (i_fast_rc & ~rc_prev) : 1'b1;
	// At or above the limit, so a smaller limit written mid-count acts at once
	assign pre_tick  = base_tick && (pre_cnt >= pre_mask(i_pre_sel));
	assign div_tick  = pre_tick && (div_cnt >= i_div);

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			rc_prev <= 1'b0;
			pre_cnt <= 6'h00;
			div_cnt <= {DIV_W{1'b0}};
			o_tick  <= 1'b0;
		end else begin
			rc_prev <= i_fast_rc;
			o_tick  <= 1'b0;
			if (!i_run || i_clear) begin
				pre_cnt <= 6'h00;
				div_cnt <= {DIV_W{1'b0}};
			end else if (base_tick) begin
				o_tick <= div_tick;
				if (pre_tick) begin
					pre_cnt <= 6'h00;
					if (div_tick)
						div_cnt <= {DIV_W{1'b0}};
					else
						div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
				end else begin
					pre_cnt <= pre_cnt + 6'h01;
				end
			end
		end
	end

endmodule // pwmg_tick
`default_nettype wire

// File: verilog/pwmg_core.v
// Counter, duty compare and interrupt event of the PWM generator
`timescale 1ns/1ns
`default_nettype none

module pwmg_core #(
	parameter CNT_W = 11
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst_n,
	// Control
	input  wire             i_run,
	input  wire             i_clear,
	input  wire             i_tick,
	input  wire             i_irq_match,
	input  wire [CNT_W-1:0] i_bound,
	input  wire [CNT_W-1:0] i_duty,
	// Results
	output reg              o_raw,
	output reg              o_irq,
	output reg  [CNT_W-1:0] o_count
);

	reg [CNT_W-1:0] next_count;

	always @* begin
		next_count = o_count;
		if (!i_run || i_clear)
			next_count = {CNT_W{1'b0}};
		else if (i_tick) begin
			if (o_count >= i_bound)
				next_count = {CNT_W{1'b0}};
			else
				next_count = o_count + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_count <= {CNT_W{1'b0}};
			o_raw   <= 1'b0;
			o_irq   <= 1'b0;
		end else begin
			o_count <= next_count;
			o_raw   <= i_run && (next_count < i_duty);
			// Event only on a counter step, so a parked value fires once
			o_irq   <= i_run && !i_clear && i_tick &&
				(i_irq_match ? (next_count == i_duty)
				             : (next_count == {CNT_W{1'b0}}));
		end
	end

endmodule // pwmg_core
`default_nettype wire

// File: verilog/pwmg_top.v
// APB register file, pin routing and top level of the 11-bit PWM generator
// ==========================================================
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_defines.vh"

module pwmg_top #(
	parameter CNT_W  = 11,
	parameter DIV_W  = 5,
	parameter ADDR_W = 12
) (
	// Clock and reset
	input  wire              I_CLK,
	input  wire              I_RST_N,
	// Fast RC oscillator, sampled as a level
	input  wire              I_INTERNAL_FAST_RC_CLOCK,
	// APB slave
	input  wire              I_PSEL,
	input  wire              I_PENABLE,
	input  wire              I_PWRITE,
	input  wire [ADDR_W-1:0] I_PADDR,
	input  wire [31:0]       I_PWDATA,
	output reg  [31:0]       O_PRDATA,
	output reg               O_PREADY,
	output reg               O_PSLVERR,
	// Port pins
	output reg               O_PORT_A_PIN_2,
	output reg               O_PORT_A_PIN_2_OE,
	output reg               O_PORT_A_PIN_3,
	output reg               O_PORT_A_PIN_3_OE,
	output reg               O_PORT_A_PIN_4,
	output reg               O_PORT_A_PIN_4_OE,
	output reg               O_PORT_A_PIN_6,
	output reg               O_PORT_A_PIN_6_OE,
	output reg               O_PORT_A_PIN_7,
	output reg               O_PORT_A_PIN_7_OE,
	// Interrupt event
	output wire              O_PWM_IRQ
);

	localparam NPIN = 5;

	// ==========================================================
	// Address decode
	function [2:0] reg_decode;
		input [ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				reg_decode = `PWMG_SEL_NONE;
			else begin
				case (addr[ADDR_W-1:2])
					`PWMG_IDX_BOUND_HIGH: reg_decode = `PWMG_SEL_BOUND_HIGH;
					`PWMG_IDX_BOUND_LOW:  reg_decode = `PWMG_SEL_BOUND_LOW;
					`PWMG_IDX_CONTROL:    reg_decode = `PWMG_SEL_CONTROL;
					`PWMG_IDX_SCALING:    reg_decode = `PWMG_SEL_SCALING;
					`PWMG_IDX_DUTY_HIGH:  reg_decode = `PWMG_SEL_DUTY_HIGH;
					`PWMG_IDX_DUTY_LOW:   reg_decode = `PWMG_SEL_DUTY_LOW;
					default:              reg_decode = `PWMG_SEL_NONE;
				endcase
			end
		end
	endfunction

	// ==========================================================
	// Register state
	reg        ctl_en;
	reg        ctl_pol;
	reg        ctl_clr;
	reg [2:0]  ctl_pin;
	reg        ctl_src;
	reg [7:0]  pwm_clock_scaling;
	reg [7:0]  pwm_bound_high;
	reg [2:0]  pwm_bound_low;
	reg [7:0]  pwm_duty_high;
	reg [2:0]  pwm_duty_low;

	wire [2:0]       sel_now;
	wire             acc_phase;
	wire             acc_done;
	wire             wr_done;
	wire [CNT_W-1:0] bound;
	wire [CNT_W-1:0] duty;
	wire             tick;
	wire             raw;
	wire             out_level;
	wire [NPIN-1:0]  pin_hit;
	reg  [7:0]       next_rdata;

	assign sel_now   = reg_decode(I_PADDR);
	assign acc_phase = I_PSEL && I_PENABLE;
	assign acc_done  = acc_phase && O_PREADY;
	assign wr_done   = acc_done && I_PWRITE;

	assign bound = {pwm_bound_high, pwm_bound_low};
	assign duty  = {pwm_duty_high, pwm_duty_low};

	// ==========================================================
	// APB handshake: one wait state, then a one-cycle ready
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= acc_phase && !O_PREADY;
			O_PSLVERR <= acc_phase && !O_PREADY &&
				(sel_now == `PWMG_SEL_NONE);
			if (acc_phase && !O_PREADY && !I_PWRITE)
				O_PRDATA <= {24'h00_0000, next_rdata};
			else
				O_PRDATA <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Read mux; write-only registers read as zero
	always @* begin
		next_rdata = `PWMG_RST_BYTE;
		case (sel_now)
			`PWMG_SEL_CONTROL: begin
				next_rdata[`PWMG_CTL_EN]  = ctl_en;
				next_rdata[`PWMG_CTL_OUT] = out_level;
				next_rdata[`PWMG_CTL_POL] = ctl_pol;
				next_rdata[`PWMG_CTL_CLR] = ctl_clr;
				next_rdata[`PWMG_CTL_PIN_HI:`PWMG_CTL_PIN_LO] = ctl_pin;
				next_rdata[`PWMG_CTL_SRC] = ctl_src;
			end
			`PWMG_SEL_SCALING: next_rdata = pwm_clock_scaling;
			default:           next_rdata = `PWMG_RST_BYTE;
		endcase
	end

	// ==========================================================
	// Register writes
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ctl_en            <= 1'b0;
			ctl_pol           <= 1'b0;
			ctl_clr           <= 1'b0;
			ctl_pin           <= `PWMG_PIN_NONE;
			ctl_src           <= 1'b0;
			pwm_clock_scaling <= `PWMG_RST_BYTE;
			pwm_bound_high    <= `PWMG_RST_BYTE;
			pwm_bound_low     <= `PWMG_RST_LOW3;
			pwm_duty_high     <= `PWMG_RST_BYTE;
			pwm_duty_low      <= `PWMG_RST_LOW3;
		end else begin
			// Clear request is consumed by the counter in the same cycle
			if (ctl_clr)
				ctl_clr <= 1'b0;
			if (wr_done) begin
				case (sel_now)
					`PWMG_SEL_CONTROL: begin
						ctl_en  <= I_PWDATA[`PWMG_CTL_EN];
						ctl_pol <= I_PWDATA[`PWMG_CTL_POL];
						// A fresh write of 1 wins over the self-clear
						if (I_PWDATA[`PWMG_CTL_CLR])
							ctl_clr <= 1'b1;
						ctl_pin <= I_PWDATA[`PWMG_CTL_PIN_HI:`PWMG_CTL_PIN_LO];
						ctl_src <= I_PWDATA[`PWMG_CTL_SRC];
					end
					`PWMG_SEL_SCALING:
						pwm_clock_scaling <= I_PWDATA[7:0];
					`PWMG_SEL_BOUND_HIGH:
						pwm_bound_high <= I_PWDATA[7:0];
					`PWMG_SEL_BOUND_LOW:
						pwm_bound_low <=
							I_PWDATA[`PWMG_LOW_HI:`PWMG_LOW_LO];
					`PWMG_SEL_DUTY_HIGH:
						pwm_duty_high <= I_PWDATA[7:0];
					`PWMG_SEL_DUTY_LOW:
						pwm_duty_low <=
							I_PWDATA[`PWMG_LOW_HI:`PWMG_LOW_LO];
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Tick generation and counter
	pwmg_tick #(
		.DIV_W (DIV_W)
	) u_tick (
		.i_clk      (I_CLK),
		.i_rst_n    (I_RST_N),
		.i_run      (ctl_en),
		.i_clear    (ctl_clr),
		.i_src_fast (ctl_src),
		.i_fast_rc  (I_INTERNAL_FAST_RC_CLOCK),
		.i_pre_sel  (pwm_clock_scaling[`PWMG_SCL_PRE_HI:`PWMG_SCL_PRE_LO]),
		.i_div      (pwm_clock_scaling[DIV_W-1:`PWMG_SCL_DIV_LO]),
		.o_tick     (tick)
	);

	pwmg_core #(
		.CNT_W (CNT_W)
	) u_core (
		.i_clk       (I_CLK),
		.i_rst_n     (I_RST_N),
		.i_run       (ctl_en),
		.i_clear     (ctl_clr),
		.i_tick      (tick),
		.i_irq_match (pwm_clock_scaling[`PWMG_SCL_IMODE]),
		.i_bound     (bound),
		.i_duty      (duty),
		.o_raw       (raw),
		.o_irq       (O_PWM_IRQ),
		.o_count     ()
	);

	// ==========================================================
	// Polarity and pin routing
	assign out_level = raw ^ ctl_pol;

	// Pin index i answers code i+2: pins 6, 7, 2, 3, 4 in that order
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
			localparam integer CODE = `PWMG_PIN_FIRST + gi;
			assign pin_hit[gi] = ctl_en && (ctl_pin == CODE[2:0]);
		end
	endgenerate

	// Reserved codes drive no pin; outputs held low when not selected
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_PORT_A_PIN_6    <= 1'b0;
			O_PORT_A_PIN_6_OE <= 1'b0;
			O_PORT_A_PIN_7    <= 1'b0;
			O_PORT_A_PIN_7_OE <= 1'b0;
			O_PORT_A_PIN_2    <= 1'b0;
			O_PORT_A_PIN_2_OE <= 1'b0;
			O_PORT_A_PIN_3    <= 1'b0;
			O_PORT_A_PIN_3_OE <= 1'b0;
			O_PORT_A_PIN_4    <= 1'b0;
			O_PORT_A_PIN_4_OE <= 1'b0;
		end else begin
			O_PORT_A_PIN_6    <= pin_hit[0] & out_level;
			O_PORT_A_PIN_6_OE <= pin_hit[0];
			O_PORT_A_PIN_7    <= pin_hit[1] & out_level;
			O_PORT_A_PIN_7_OE <= pin_hit[1];
			O_PORT_A_PIN_2    <= pin_hit[2] & out_level;
			O_PORT_A_PIN_2_OE <= pin_hit[2];
			O_PORT_A_PIN_3    <= pin_hit[3] & out_level;
			O_PORT_A_PIN_3_OE <= pin_hit[3];
			O_PORT_A_PIN_4    <= pin_hit[4] & out_level;
			O_PORT_A_PIN_4_OE <= pin_hit[4];
		end
	end

endmodule // pwmg_top
`default_nettype wire

// File: bench/pwmg_load.sv
// Pulled-down load on the five port pins of the generator
`timescale 1ns/1ns
`default_nettype none
module pwmg_load (
	// Pins in the order pin 2, 3, 4, 6, 7
	input	wire logic [4:0]	i_pin,
	input	wire logic [4:0]	i_oe,
	// Levels seen on the lines
	output	logic [4:0]		o_lvl
);
	// Released lines fall to the pull-down
	assign o_lvl = i_pin & i_oe;
endmodule // pwmg_load
`default_nettype wire

// File: bench/pwmg_top_properties.sv
// Bus and pin properties of the PWM generator top
`timescale 1ns/1ns
`default_nettype none
module pwmg_top_properties #(
	parameter ADDR_W = 12
) (
	// Clock, reset and bus
	input	wire logic		I_CLK,
	input	wire logic		I_RST_N,
	input	wire logic		I_PSEL,
	input	wire logic		I_PENABLE,
	input	wire logic		I_PWRITE,
	input	wire logic [ADDR_W-1:0]	I_PADDR,
	input	wire logic [31:0]	O_PRDATA,
	input	wire logic		O_PREADY,
	input	wire logic		O_PSLVERR,
	// Pins and event
	input	wire logic		O_PORT_A_PIN_2,
	input	wire logic		O_PORT_A_PIN_2_OE,
	input	wire logic		O_PORT_A_PIN_3,
	input	wire logic		O_PORT_A_PIN_3_OE,
	input	wire logic		O_PORT_A_PIN_4,
	input	wire logic		O_PORT_A_PIN_4_OE,
	input	wire logic		O_PORT_A_PIN_6,
	input	wire logic		O_PORT_A_PIN_6_OE,
	input	wire logic		O_PORT_A_PIN_7,
	input	wire logic		O_PORT_A_PIN_7_OE,
	input	wire logic		O_PWM_IRQ
);
	wire [4:0] oe_v = {O_PORT_A_PIN_2_OE, O_PORT_A_PIN_3_OE,
		O_PORT_A_PIN_4_OE, O_PORT_A_PIN_6_OE, O_PORT_A_PIN_7_OE};
	wire [4:0] pin_v = {O_PORT_A_PIN_2, O_PORT_A_PIN_3,
		O_PORT_A_PIN_4, O_PORT_A_PIN_6, O_PORT_A_PIN_7};
	wire wr_ctl = O_PREADY && I_PWRITE && I_PADDR == 12'h0c0;
	wire wo_a = I_PADDR == 12'h068 || I_PADDR == 12'h06c ||
		I_PADDR == 12'h0c8 || I_PADDR == 12'h0cc;
	default clocking dcb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// ==========================================================
	// Properties
	a_ready_wait:
	assert property (I_PSEL && $rose(I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
		else $error("pready not after one wait state");
	a_ready_pulse:
	assert property (O_PREADY |=> !O_PREADY)
		else $error("pready longer than one cycle");
	a_ready_access:
	assert property (O_PREADY |-> I_PSEL && I_PENABLE)
		else $error("pready outside access phase");
	a_rdata_idle:
	assert property (!O_PREADY || I_PWRITE |-> O_PRDATA == 32'h0000_0000)
		else $error("read data outside a read answer");
	a_err_misalign:
	assert property (O_PREADY && I_PADDR[1:0] != 2'h0 |-> O_PSLVERR)
		else $error("misaligned access not refused");
	a_wo_zero:
	assert property (O_PREADY && !I_PWRITE && wo_a |-> O_PRDATA == 0)
		else $error("write-only register read not zero");
	a_pin_one:
	assert property ($onehot0(oe_v))
		else $error("more than one pin driven");
	a_pin_idle:
	assert property ((pin_v & ~oe_v) == 5'h00)
		else $error("undriven pin not low");
	a_oe_write:
	assert property ($changed(oe_v) |->
		$past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3))
		else $error("pin enable changed without control write");
	c_irq: cover property (O_PWM_IRQ);
	c_err: cover property (O_PREADY && O_PSLVERR);
	c_oe: cover property (|oe_v);
	c_pin: cover property ($rose(|pin_v));
endmodule // pwmg_top_properties
`default_nettype wire

// File: bench/tb_pwm_generator_11bit.sv
// Register-level testbench of the PWM generator top
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_defines.vh"
module tb_pwm_generator_11bit;
	localparam [11:0] A_BH = 4 * `PWMG_IDX_BOUND_HIGH;
	localparam [11:0] A_BL = 4 * `PWMG_IDX_BOUND_LOW;
	localparam [11:0] A_C = 4 * `PWMG_IDX_CONTROL;
	localparam [11:0] A_S = 4 * `PWMG_IDX_SCALING;
	localparam [11:0] A_DH = 4 * `PWMG_IDX_DUTY_HIGH;
	localparam [11:0] A_DL = 4 * `PWMG_IDX_DUTY_LOW;
	// Enabled pin per pin code, one byte each
	localparam [63:0] PM = 64'h0004_0810_0102_0000;
	logic		clk, rst_n, psel, pen, pwr, pready, pslverr, irq, e;
	logic [2:0]	rcc;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, r, hi, per, g, d0, d1, f;
	logic [4:0]	pins, oes, lvl;
	int		miscompares, n_checks, cyc;
	pwmg_top dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_INTERNAL_FAST_RC_CLOCK(rcc[2]),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr),
		.O_PORT_A_PIN_2(pins[4]), .O_PORT_A_PIN_2_OE(oes[4]),
		.O_PORT_A_PIN_3(pins[3]), .O_PORT_A_PIN_3_OE(oes[3]),
		.O_PORT_A_PIN_4(pins[2]), .O_PORT_A_PIN_4_OE(oes[2]),
		.O_PORT_A_PIN_6(pins[1]), .O_PORT_A_PIN_6_OE(oes[1]),
		.O_PORT_A_PIN_7(pins[0]), .O_PORT_A_PIN_7_OE(oes[0]),
		.O_PWM_IRQ(irq)
	);
	pwmg_load u_load (.i_pin(pins), .i_oe(oes), .o_lvl(lvl));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Fast RC source, one rising edge every 8 cycles
	always @(posedge clk) rcc <= rcc + 3'h1;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	// ==========================================================
	// Tasks
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			miscompares++;
			$display("ERROR at %0t: saw %h, expected %h", $time, s, x);
		end
	endtask
	task automatic meas;
		@(posedge clk iff lvl[1] === 1'b0);
		@(posedge clk iff lvl[1] === 1'b1);
		hi = 0;
		per = 0;
		while (lvl[1] === 1'b1) begin
			@(posedge clk);
			hi++;
			per++;
		end
		while (lvl[1] === 1'b0) begin
			@(posedge clk);
			per++;
		end
	endtask
	task automatic irqgap(output logic [31:0] gap, output logic [31:0] dly);
		logic p, q;
		repeat (8) @(posedge clk);
		@(posedge clk iff irq === 1'b1);
		gap = 0;
		do begin
			@(posedge clk);
			gap++;
		end while (irq !== 1'b1);
		p = lvl[1];
		dly = 0;
		do begin
			@(posedge clk);
			dly++;
			q = p;
			p = lvl[1];
		end while (q !== 1'b0 || p !== 1'b1);
	endtask
	task report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		int p;
		{psel, pen, pwr, rst_n, rcc, paddr, pwdata} = 0;
		{cyc, miscompares, n_checks} = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_C);
		chk(r, 32'h0000_0000);
		rd(A_S);
		chk(r, 32'h0000_0000);
		rd(A_BH);
		chk(r, 32'h0000_0000);
		rd(12'h0c1);
		chk(32'(e), 32'h0000_0001);
		wr(A_BL, 32'h0000_0060);
		wr(A_DH, 32'h0000_0000);
		wr(A_DL, 32'h0000_0040);
		rd(A_DL);
		chk(r, 32'h0000_0000);
		wr(A_C, 32'h0000_0084);
		for (p = 0; p < 4; p++) begin
			f = (32'h0000_0001 << (2 * p)) * (p + 1);
			wr(A_S, (p << 5) | p);
			rd(A_S);
			chk(r, (p << 5) | p);
			meas;
			chk(per, 4 * f);
			chk(hi, 2 * f);
		end
		wr(A_S, 32'h0000_0000);
		irqgap(g, d0);
		chk(g, 4);
		wr(A_S, 32'h0000_0080);
		irqgap(g, d1);
		chk(g, 4);
		chk((d0 - d1) & 32'h0000_0003, 2);
		wr(A_S, 32'h0000_0000);
		wr(A_C, 32'h0000_0085);
		meas;
		chk(per, 32);
		// Ticks every 16 cycles: cleared counter holds the pin high 2 ticks
		wr(A_S, 32'h0000_0040);
		wr(A_C, 32'h0000_0094);
		repeat (3) @(posedge clk);
		g = 3;
		while (lvl[1] === 1'b1) begin
			@(posedge clk);
			g++;
		end
		chk(g, 36);
		rd(A_C);
		chk(r & 32'h0000_00bf, 32'h0000_0084);
		wr(A_DL, 32'h0000_0000);
		for (p = 0; p < 8; p++) begin
			wr(A_C, 32'h0000_00a0 | (p << 1));
			repeat (3) @(posedge clk);
			chk(32'(oes), 32'(PM[8 * p +: 5]));
			chk(32'(lvl), 32'(PM[8 * p +: 5]));
		end
		wr(A_C, 32'h0000_00a4);
		repeat (3) @(posedge clk);
		chk(32'(lvl[1]), 1);
		rd(A_C);
		chk(r & 32'h0000_00e0, 32'h0000_00e0);
		wr(A_C, 32'h0000_0024);
		repeat (3) @(posedge clk);
		chk(32'(oes), 0);
		report_and_stop;
	end
endmodule // tb_pwm_generator_11bit
bind pwmg_top pwmg_top_properties #(.ADDR_W(ADDR_W)) u_prop (
	.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.O_PORT_A_PIN_2(O_PORT_A_PIN_2), .O_PORT_A_PIN_2_OE(O_PORT_A_PIN_2_OE),
	.O_PORT_A_PIN_3(O_PORT_A_PIN_3), .O_PORT_A_PIN_3_OE(O_PORT_A_PIN_3_OE),
	.O_PORT_A_PIN_4(O_PORT_A_PIN_4), .O_PORT_A_PIN_4_OE(O_PORT_A_PIN_4_OE),
	.O_PORT_A_PIN_6(O_PORT_A_PIN_6), .O_PORT_A_PIN_6_OE(O_PORT_A_PIN_6_OE),
	.O_PORT_A_PIN_7(O_PORT_A_PIN_7), .O_PORT_A_PIN_7_OE(O_PORT_A_PIN_7_OE),
	.O_PWM_IRQ(O_PWM_IRQ)
);
`default_nettype wire
